/* File: dv/scsc_peer.sv */
/* channel core stand-in: turns bench requests into one-cycle event and clear pulses.
   assumes requests are held by the bench for one pclk cycle only. */
`timescale 1ns/1ps
module scsc_peer (
  input wire logic pclk, // clock
  input wire logic [2:0] ev_req, // {ovr,par,frm} events to raise
  input wire logic [2:0] clr_req, // flags to clear
  output logic overrun_evt, // overrun pulse
  output logic par_und_evt, // parity or underrun pulse
  output logic framing_evt, // framing pulse
  output logic [2:0] flag_clr // clear pulses
);
  // registered so every pulse is exactly one cycle, as the core would give
  always_ff @(posedge pclk) begin
    {overrun_evt, par_und_evt, framing_evt} <= ev_req;
    flag_clr <= clr_req;
  end
endmodule : scsc_peer

/* File: dv/scsc_top_test.sv */
/* self-checking bench for scsc_top: apb master, error events, interrupt.
   assumes the scsc_peer model drives the event and clear ports. */
`timescale 1ns/1ps
module scsc_top_test;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, d;
  logic pready, pslverr, er, edge_o, src_o, irq, ovr, par, frm;
  logic [2:0] flag_clr, ev_req = 3'h0, clr_req = 3'h0, flags = 3'h0, ev;
  logic [1:0] ctl = 2'h0;
  int errors = 0, checks_done = 0, seed = 95258;
  always #2.5 pclk = ~pclk;
  scsc_peer peer (.pclk(pclk), .ev_req(ev_req), .clr_req(clr_req), .overrun_evt(ovr),
    .par_und_evt(par), .framing_evt(frm), .flag_clr(flag_clr));
  scsc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .overrun_evt(ovr), .par_und_evt(par), .framing_evt(frm),
    .flag_clr(flag_clr), .serial_clock_edge_select(edge_o), .io_clock_source_select(src_o),
    .irq(irq));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one apb transfer; pready, read data and error are taken at the completing edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    if (n >= 20) chk(32'h1, 32'h0);
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask : apb
  // events win over clears in the same cycle
  task pulse(input logic [2:0] e, input logic [2:0] c);
    ev_req <= e; clr_req <= c;
    @(posedge pclk);
    ev_req <= 3'h0; clr_req <= 3'h0;
    repeat (3) @(posedge pclk);
    flags = e | (flags & ~c);
  endtask : pulse
  function automatic logic [31:0] ctrl_exp();
    return {27'h0, flags, ctl};
  endfunction : ctrl_exp
  task complete_run;
    if (errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, scsc_pkg::ctrl_off, 32'h0); chk(rd, ctrl_exp());
    apb(0, scsc_pkg::irq_mask_off, 32'h0); chk(rd, 32'h0);
    apb(1, 8'h0c, 32'hffff_ffff); chk({31'h0, er}, 32'h1);
    apb(0, 8'h0c, 32'h0); chk({31'h0, er}, 32'h1); chk(rd, 32'h0);
    // random events, clears and control writes; first two writes are corner words
    for (int i = 0; i < 24; i++) begin
      ev = 3'($random(seed));
      pulse(ev, 3'($random(seed)));
      d = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0 : $random(seed);
      // internal clock source means clock output mode: keep the edge bit 0 then
      d[1] = d[1] & d[0];
      apb(1, scsc_pkg::ctrl_off, d);
      ctl = d[1:0];
      @(posedge pclk);
      @(negedge pclk);
      chk({30'h0, edge_o, src_o}, {30'h0, ctl});
      @(posedge pclk);
      apb(0, scsc_pkg::ctrl_off, 32'h0); chk(rd, ctrl_exp());
    end
    // interrupt: raise, clear by status read, then masked; a set mask bit passes its event
    apb(0, scsc_pkg::irq_stat_off, 32'h0);
    apb(1, scsc_pkg::irq_mask_off, 32'h7);
    pulse(3'h4, 3'h0);
    @(negedge pclk); chk({31'h0, irq}, 32'h1);
    @(posedge pclk);
    apb(0, scsc_pkg::irq_stat_off, 32'h0); chk(rd, 32'h4);
    @(negedge pclk); chk({31'h0, irq}, 32'h0);
    @(posedge pclk);
    apb(0, scsc_pkg::irq_stat_off, 32'h0); chk(rd, 32'h0);
    apb(1, scsc_pkg::irq_mask_off, 32'h0);
    pulse(3'h3, 3'h0);
    @(negedge pclk); chk({31'h0, irq}, 32'h0);
    @(posedge pclk);
    apb(0, scsc_pkg::irq_stat_off, 32'h0); chk(rd, 32'h3);
    apb(0, scsc_pkg::ctrl_off, 32'h0); chk(rd, ctrl_exp());
    complete_run();
  end
  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    complete_run();
  end
endmodule : scsc_top_test

/* File: logic/scsc_flag.sv */
/*
 * one sticky error flag: set by a hardware event, cleared by a clear pulse.
 * assumes events and clears are synchronous to pclk.
 */
`timescale 1ns/1ps
module scsc_flag (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  input wire logic set_i, // error event pulse
  input wire logic clr_i, // clear pulse
  output logic flag_r // flag value
);
  // set wins over a clear in the same cycle so no event is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r <= 1'b0;
    end else if (set_i) begin
      flag_r <= 1'b1;
    end else if (clr_i) begin
      flag_r <= 1'b0;
    end
  end
endmodule : scsc_flag

/* File: logic/scsc_pkg.sv */
/*
 * package for the serial channel status and clock select block: register
 * offsets, bit positions and reset values.
 * assumes a 32-bit apb bus with word-aligned registers.
 */
package scsc_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ctrl_off = 8'h00; // control and error flags
  localparam logic [7:0] irq_stat_off = 8'h04; // sticky event status, clear on read
  localparam logic [7:0] irq_mask_off = 8'h08; // interrupt mask
  // ---------------------------------------------------------------
  // bit positions of the control register
  // ---------------------------------------------------------------
  localparam int overrun_bit = 4;
  localparam int par_und_bit = 3;
  localparam int framing_bit = 2;
  localparam int edge_sel_bit = 1;
  localparam int clk_src_bit = 0;
  // event bits in status and mask registers
  localparam int ev_overrun = 2;
  localparam int ev_par_und = 1;
  localparam int ev_framing = 0;
  localparam int ev_width = 3;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] clk_ctrl_rst = 2'h0;
  localparam logic [2:0] ev_rst = 3'h0;
  localparam logic [31:0] rdata_rst = 32'h0000_0000;
endpackage : scsc_pkg

/* File: logic/scsc_top.sv */
/*
 * serial channel status and clock select: three error flags, clock edge and
 * clock source controls for clocked mode, event interrupt, apb slave.
 * assumes the channel core reports error events as one-cycle pulses and
 * clears flags by pulses; all inputs synchronous to pclk.
 */
// The register offsets and register access over APB were decided locally.
`timescale 1ns/1ps
module scsc_top (
  input wire logic pclk, // clock, 200 mhz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic overrun_evt, // overrun detected pulse
  input wire logic par_und_evt, // parity or underrun detected pulse
  input wire logic framing_evt, // framing error detected pulse
  input wire logic [2:0] flag_clr, // flag clear pulses {ovr,par,frm}
  output logic serial_clock_edge_select, // 1 falling, 0 rising
  output logic io_clock_source_select, // 0 baud rate generator
  output logic irq // level interrupt
);
  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic setup;
  logic wr_en;
  logic rd_en;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_mask;
  logic mapped;
  logic [2:0] evt;
  logic [2:0] flags;
  logic [1:0] clk_ctrl_r;
  logic [2:0] stat_r;
  logic [2:0] mask_r;
  logic [2:0] stat_nxt;

  // answer in the setup-following cycle: access phase completes at once
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && pready;
  assign rd_en = psel && penable && !pwrite && pready;
  assign hit_ctrl = (paddr == scsc_pkg::ctrl_off);
  assign hit_stat = (paddr == scsc_pkg::irq_stat_off);
  assign hit_mask = (paddr == scsc_pkg::irq_mask_off);
  assign mapped = hit_ctrl || hit_stat || hit_mask;
  assign evt = {overrun_evt, par_und_evt, framing_evt};

  // ---------------------------------------------------------------
  // error flags
  // ---------------------------------------------------------------
  // flags only take hardware events and clears, never bus writes
  genvar g;
  generate
    for (g = 0; g < scsc_pkg::ev_width; g = g + 1) begin : g_flag
      scsc_flag u_flag (
        .pclk(pclk),
        .presetn(presetn),
        .set_i(evt[g]),
        .clr_i(flag_clr[g]),
        .flag_r(flags[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // clock controls
  // ---------------------------------------------------------------
  // edge select and source select; the edge bit is not forced to 0 in
  // clock output mode, software owns that setting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_ctrl_r <= scsc_pkg::clk_ctrl_rst;
    end else if (wr_en && hit_ctrl) begin
      clk_ctrl_r <= {pwdata[scsc_pkg::edge_sel_bit], pwdata[scsc_pkg::clk_src_bit]};
    end
  end

  // registered copies to the channel core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_clock_edge_select <= 1'b0;
      io_clock_source_select <= 1'b0;
    end else begin
      serial_clock_edge_select <= clk_ctrl_r[1];
      io_clock_source_select <= clk_ctrl_r[0];
    end
  end

  // ---------------------------------------------------------------
  // interrupt status and mask
  // ---------------------------------------------------------------
  // read clears, but an event in the same cycle survives
  always_comb begin
    stat_nxt = stat_r;
    if (rd_en && hit_stat) begin
      stat_nxt = scsc_pkg::ev_rst;
    end
    stat_nxt = stat_nxt | evt;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= scsc_pkg::ev_rst;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= scsc_pkg::ev_rst;
    end else if (wr_en && hit_mask) begin
      mask_r <= pwdata[scsc_pkg::ev_width-1:0];
    end
  end

  // irq reflects next-state so it stays aligned with the status register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat_nxt & mask_r);
    end
  end

  // ---------------------------------------------------------------
  // bus answer
  // ---------------------------------------------------------------
  // pready rises the cycle after setup: one wait-free access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= scsc_pkg::rdata_rst;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      prdata <= scsc_pkg::rdata_rst;
      if (setup && !pwrite) begin
        if (hit_ctrl) begin
          prdata[scsc_pkg::overrun_bit] <= flags[scsc_pkg::ev_overrun];
          prdata[scsc_pkg::par_und_bit] <= flags[scsc_pkg::ev_par_und];
          prdata[scsc_pkg::framing_bit] <= flags[scsc_pkg::ev_framing];
          prdata[scsc_pkg::edge_sel_bit] <= clk_ctrl_r[1];
          prdata[scsc_pkg::clk_src_bit] <= clk_ctrl_r[0];
        end else if (hit_stat) begin
          // next-state so an event landing on the setup edge is read before
          // the access edge clears it; otherwise it would vanish unseen
          prdata[scsc_pkg::ev_width-1:0] <= stat_nxt;
        end else if (hit_mask) begin
          prdata[scsc_pkg::ev_width-1:0] <= mask_r;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_overrun_sets: assert property (@(posedge pclk) disable iff (!presetn)
    overrun_evt |=> flags[scsc_pkg::ev_overrun]) else $error("overrun flag not set");
  a_par_und_sets: assert property (@(posedge pclk) disable iff (!presetn)
    par_und_evt |=> flags[scsc_pkg::ev_par_und]) else $error("parity flag not set");
  a_framing_sets: assert property (@(posedge pclk) disable iff (!presetn)
    framing_evt |=> flags[scsc_pkg::ev_framing]) else $error("framing flag not set");
  a_flag_write_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && hit_ctrl && evt == 3'h0 && flag_clr == 3'h0) |=> $stable(flags))
    else $error("write changed error flags");
  sequence s_ctrl_write;
    psel && penable && pwrite && pready && hit_ctrl;
  endsequence
  a_edge_follows_write: assert property (@(posedge pclk) disable iff (!presetn)
    s_ctrl_write |=> ##1
    serial_clock_edge_select == $past(pwdata[scsc_pkg::edge_sel_bit], 2))
    else $error("edge select not updated");
  a_src_follows_write: assert property (@(posedge pclk) disable iff (!presetn)
    s_ctrl_write |-> ##2 io_clock_source_select == $past(pwdata[scsc_pkg::clk_src_bit], 2))
    else $error("clock source not updated");
  a_ready_after_setup: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> pready) else $error("no ready after setup");
  a_irq_masked_off: assert property (@(posedge pclk) disable iff (!presetn)
    (mask_r == 3'h0) [*2] |-> !irq) else $error("irq with all masked");
  // read data must carry the flags as they stood at the setup edge
  sequence s_ctrl_read_setup;
    psel && !penable && !pwrite && hit_ctrl;
  endsequence
  a_ctrl_read_flags: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_ctrl_read_setup |=>
    prdata[scsc_pkg::overrun_bit:scsc_pkg::framing_bit] == $past(flags))
    else $error("error flags misread");
  // a status read with no event in the same cycle leaves nothing behind
  sequence s_stat_read_quiet;
    rd_en && hit_stat && (evt == scsc_pkg::ev_rst);
  endsequence
  a_stat_read_clears: assert property (@(posedge pclk) disable iff (!presetn)
    s_stat_read_quiet |=> stat_r == scsc_pkg::ev_rst) else $error("status not cleared");
  // an unmasked pending event must reach the pin unless a read clears it
  a_irq_raised: assert property (@(posedge pclk) disable iff (!presetn)
    ((stat_r & mask_r) != scsc_pkg::ev_rst) && !(rd_en && hit_stat) |=> irq)
    else $error("irq missing for unmasked event");
  // an unmapped offset must answer with an error, never a silent success
  a_unmapped_error: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !mapped) |=> pslverr) else $error("no error for unmapped offset");
  // a clear pulse with no event in that cycle drops the flag
  a_overrun_clears: assert property (@(posedge pclk) disable iff (!presetn)
    (flag_clr[scsc_pkg::ev_overrun] && !overrun_evt) |=> !flags[scsc_pkg::ev_overrun])
    else $error("overrun flag not cleared");
endmodule : scsc_top
